// >>> design/charger_cfg_pkg.sv
// Purpose: Constants for the charger protection and thermal configuration registers.
// Assumes: 50 MHz reference clock, APB register access, temperatures in whole degrees C.
// Notes:   Register offsets are word indices; the byte address is four times the index.
package charger_cfg_pkg;
  localparam logic [7:0]  IDX_SWITCH_CFG   = 8'h11;
  localparam logic [7:0]  IDX_THERMAL_CFG  = 8'h12;
  localparam logic [7:0]  IDX_STATUS       = 8'h13;
  localparam logic [7:0]  RST_SWITCH_CFG   = 8'h30;
  localparam logic [7:0]  RST_THERMAL_CFG  = 8'h05;
  localparam int          POS_WD_CLEAR     = 0;
  localparam int          POS_LEGACY_WD    = 2;
  localparam int          POS_KEEP_SWITCH  = 3;
  localparam int          POS_OC_THRESH    = 4;
  localparam int          POS_WD_PERIOD    = 6;
  localparam int          POS_NO_INPUT_OC  = 7;
  localparam int          POS_THM_MODE     = 0;
  localparam int          POS_JUNC_SET     = 2;
  localparam int          POS_COLD_SEL     = 4;
  localparam int          POS_HOT_SEL      = 5;
  localparam int          POS_ST_WD_EXP    = 0;
  localparam int          POS_ST_SW_OPEN   = 1;
  localparam int          POS_ST_TREG      = 2;
  localparam int          POS_ST_SUSPEND   = 3;
  localparam int          POS_ST_CUR_RED   = 4;
  localparam int          POS_ST_VOLT_RED  = 5;
  localparam int          POS_ST_OC_NOW    = 6;
  localparam logic [1:0]  WD_CLEAR_CODE    = 2'h1;
  localparam int          CLK_PERIOD_NS    = 20;
  localparam int          TICK_NS          = 1000000;
  localparam int          TICK_CYCLES      = TICK_NS / CLK_PERIOD_NS;
  localparam int          WD_LONG_S        = 80;
  localparam int          WD_SHORT_S       = 32;
  localparam logic [16:0] WD_LONG_MS       = 17'(WD_LONG_S * 1000);
  localparam logic [16:0] WD_SHORT_MS      = 17'(WD_SHORT_S * 1000);
  localparam logic [16:0] OC_QUAL_MS       = 17'h00010;
  localparam logic [11:0] OC_LIM_LOW_MA    = 12'h898;
  localparam logic [11:0] OC_LIM_MID_MA    = 12'hAF0;
  localparam logic [11:0] OC_LIM_HIGH_MA   = 12'hC80;
  localparam logic [7:0]  JUNC_80_C        = 8'h50;
  localparam logic [7:0]  JUNC_95_C        = 8'h5F;
  localparam logic [7:0]  JUNC_110_C       = 8'h6E;
  localparam logic [7:0]  COLD_LOW_C       = 8'h00;
  localparam logic [7:0]  COLD_HIGH_C      = 8'h0A;
  localparam logic [7:0]  HOT_LOW_SEL_C    = 8'h3C;
  localparam logic [7:0]  HOT_HIGH_SEL_C   = 8'h37;
  localparam logic [7:0]  COOL_C           = 8'h0A;
  localparam logic [7:0]  WARM_C           = 8'h2D;
  typedef enum logic [3:0] {
    THM_OFF   = 4'h1,
    THM_STOP  = 4'h2,
    THM_CV_CC = 4'h4,
    THM_CC    = 4'h8
  } thm_mode_t;
endpackage

// >>> design/hold_timer.sv
// Purpose: Counts millisecond ticks while a condition holds and flags the limit.
// Assumes: i_tick is a one-cycle enable pulse; i_run low restarts the count.
// Notes:   o_done is a level that stays high while i_run holds at the limit.
`timescale 1ns/10ps
`default_nettype none
module hold_timer (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  input  wire logic        i_run,
  input  wire logic        i_tick,
  input  wire logic [16:0] i_limit,
  output logic      [16:0] o_count,
  output logic             o_done
);
  logic [16:0] count;
  logic [16:0] next_count;

  always_comb begin
    next_count = count;
    if (!i_run) begin
      next_count = 17'h00000;
    end else if (i_tick && count < i_limit) begin
      next_count = count + 17'h00001;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      count <= 17'h00000;
    end else begin
      count <= next_count;
    end
  end

  assign o_count = count;
  assign o_done  = i_run && (count >= i_limit);
endmodule
`default_nettype wire

// >>> design/charger_protect_thermal_cfg.sv
// Purpose: Protection and thermal configuration registers with their control logic.
// Assumes: APB slave with no wait states; current in mA, temperatures in degrees C.
// Notes:   The core digital reset and the system reset both restore every field.
//
// The APB register port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module charger_protect_thermal_cfg #(
  parameter int TICK_CYCLES_P = charger_cfg_pkg::TICK_CYCLES
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_core_digital_reset_n,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [3:0]  i_pstrb,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_watchdog_enable,
  input  wire logic        i_input_present,
  input  wire logic [11:0] i_batt_current_ma,
  input  wire logic [7:0]  i_batt_temp_c,
  input  wire logic [7:0]  i_junction_temp_c,
  output logic             o_watchdog_expired,
  output logic             o_battery_system_switch_open,
  output logic             o_charge_suspend,
  output logic             o_current_reduce,
  output logic             o_voltage_reduce,
  output logic             o_current_foldback,
  output logic             o_cool_event,
  output logic             o_warm_event
);
  import charger_cfg_pkg::*;

  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] idx);
    addr_hit = (addr[7:2] == idx[5:0]) && (addr[1:0] == 2'h0) && (idx[7:6] == 2'h0);
  endfunction

  function automatic logic [11:0] oc_limit(input logic [1:0] sel);
    unique case (sel)
      2'h1:    oc_limit = OC_LIM_LOW_MA;
      2'h2:    oc_limit = OC_LIM_MID_MA;
      default: oc_limit = OC_LIM_HIGH_MA;
    endcase
  endfunction

  logic        core_rst;
  logic        setup_phase;
  logic        access_phase;
  logic        mapped;
  logic        wr_switch;
  logic        wr_thermal;
  logic        wr_status;
  logic [7:0]  switch_cfg;
  logic [7:0]  thermal_cfg;
  logic [7:0]  next_switch_cfg;
  logic [7:0]  next_thermal_cfg;
  logic [7:0]  status;
  logic [31:0] prdata;
  logic [31:0] next_prdata;

  // Either reset source restores the register defaults.
  assign core_rst     = i_sys_rst || !i_core_digital_reset_n;
  assign setup_phase  = i_psel && !i_penable;
  assign access_phase = i_psel && i_penable;
  assign mapped       = addr_hit(i_paddr, IDX_SWITCH_CFG) || addr_hit(i_paddr, IDX_THERMAL_CFG)
                        || addr_hit(i_paddr, IDX_STATUS);
  assign wr_switch    = access_phase && i_pwrite && i_pstrb[0]
                        && addr_hit(i_paddr, IDX_SWITCH_CFG);
  assign wr_thermal   = access_phase && i_pwrite && i_pstrb[0]
                        && addr_hit(i_paddr, IDX_THERMAL_CFG);
  assign wr_status    = access_phase && i_pwrite && i_pstrb[0] && addr_hit(i_paddr, IDX_STATUS);
  assign o_pready     = 1'b1;
  assign o_pslverr    = access_phase && !mapped;
  assign o_prdata     = prdata;

  always_comb begin
    next_switch_cfg  = switch_cfg;
    next_thermal_cfg = thermal_cfg;
    next_prdata      = prdata;
    // The legacy watchdog switch bit is only stored; nothing else reads it.
    if (wr_switch) begin
      next_switch_cfg = i_pwdata[7:0];
    end
    // Bit six of the thermal register is spare storage, kept read/write.
    if (wr_thermal) begin
      next_thermal_cfg = i_pwdata[7:0];
    end
    if (setup_phase) begin
      if (addr_hit(i_paddr, IDX_SWITCH_CFG)) begin
        next_prdata = {24'h000000, switch_cfg};
      end else if (addr_hit(i_paddr, IDX_THERMAL_CFG)) begin
        next_prdata = {24'h000000, thermal_cfg};
      end else if (addr_hit(i_paddr, IDX_STATUS)) begin
        next_prdata = {24'h000000, status};
      end else begin
        next_prdata = 32'h00000000;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (core_rst) begin
      switch_cfg  <= RST_SWITCH_CFG;
      thermal_cfg <= RST_THERMAL_CFG;
      prdata      <= 32'h00000000;
    end else begin
      switch_cfg  <= next_switch_cfg;
      thermal_cfg <= next_thermal_cfg;
      prdata      <= next_prdata;
    end
  end

  logic [1:0] oc_thresh;
  logic [1:0] junc_set;
  logic       keep_switch;
  logic       no_input_oc;
  logic       wd_short;
  logic       cold_sel;
  logic       hot_sel;
  assign oc_thresh   = switch_cfg[POS_OC_THRESH +: 2];
  assign keep_switch = switch_cfg[POS_KEEP_SWITCH];
  assign no_input_oc = switch_cfg[POS_NO_INPUT_OC];
  assign wd_short    = switch_cfg[POS_WD_PERIOD];
  assign junc_set    = thermal_cfg[POS_JUNC_SET +: 2];
  assign cold_sel    = thermal_cfg[POS_COLD_SEL];
  assign hot_sel     = thermal_cfg[POS_HOT_SEL];

  // One millisecond enable shared by both timers keeps their counters narrow.
  logic [31:0] tick_div;
  logic [31:0] next_tick_div;
  logic        tick;
  assign tick = (tick_div == 32'(TICK_CYCLES_P - 1));

  always_comb begin
    next_tick_div = tick ? 32'h00000000 : tick_div + 32'h00000001;
  end

  always_ff @(posedge i_ref_clk) begin
    if (core_rst) begin
      tick_div <= 32'h00000000;
    end else begin
      tick_div <= next_tick_div;
    end
  end

  logic        wd_restart;
  logic        wd_run;
  logic [16:0] wd_limit;
  logic [16:0] wd_count;
  logic        wd_done;
  logic        oc_cond;
  logic        oc_done;
  logic [16:0] oc_count;
  logic        wd_expired;
  logic        switch_open;
  logic        next_wd_expired;
  logic        next_switch_open;

  assign wd_restart = wr_switch && (i_pwdata[POS_WD_CLEAR +: 2] == WD_CLEAR_CODE);
  assign wd_run     = i_watchdog_enable && !wd_restart;
  assign wd_limit   = wd_short ? WD_SHORT_MS : WD_LONG_MS;
  // Without an input supply the check runs only when software asks for it.
  assign oc_cond    = (oc_thresh != 2'h0) && (i_batt_current_ma > oc_limit(oc_thresh))
                      && (i_input_present || no_input_oc);

  hold_timer u_watchdog (
    .i_ref_clk (i_ref_clk),
    .i_rst     (core_rst),
    .i_run     (wd_run),
    .i_tick    (tick),
    .i_limit   (wd_limit),
    .o_count   (wd_count),
    .o_done    (wd_done)
  );

  // Dropping the condition zeroes the count, so only a continuous overcurrent qualifies.
  hold_timer u_overcurrent (
    .i_ref_clk (i_ref_clk),
    .i_rst     (core_rst),
    .i_run     (oc_cond),
    .i_tick    (tick),
    .i_limit   (OC_QUAL_MS),
    .o_count   (oc_count),
    .o_done    (oc_done)
  );

  // Hardware set wins over a software clear in the same cycle.
  always_comb begin
    next_wd_expired  = wd_expired;
    next_switch_open = switch_open;
    if (wr_status && i_pwdata[POS_ST_WD_EXP]) begin
      next_wd_expired = 1'b0;
    end
    if (wr_status && i_pwdata[POS_ST_SW_OPEN]) begin
      next_switch_open = 1'b0;
    end
    if (wd_done) begin
      next_wd_expired = 1'b1;
    end
    if (oc_done && !keep_switch) begin
      next_switch_open = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (core_rst) begin
      wd_expired  <= 1'b0;
      switch_open <= 1'b0;
    end else begin
      wd_expired  <= next_wd_expired;
      switch_open <= next_switch_open;
    end
  end

  assign o_watchdog_expired           = wd_expired;
  assign o_battery_system_switch_open = switch_open;

  thm_mode_t   thm_mode;
  logic signed [7:0] temp;
  logic signed [7:0] cold_limit;
  logic signed [7:0] hot_limit;
  logic [7:0]  junc_limit;
  logic        beyond_cool_warm;
  logic        is_cool;
  logic        is_warm;
  logic        was_cool;
  logic        was_warm;
  logic        suspend;
  logic        cur_red;
  logic        volt_red;
  logic        foldback;
  logic        next_suspend;
  logic        next_cur_red;
  logic        next_volt_red;
  logic        next_foldback;
  logic        next_cool_event;
  logic        next_warm_event;
  logic        cool_event;
  logic        warm_event;

  assign thm_mode = thm_mode_t'(4'h1 << thermal_cfg[POS_THM_MODE +: 2]);

  assign temp       = i_batt_temp_c;
  assign cold_limit = cold_sel ? COLD_HIGH_C : COLD_LOW_C;
  assign hot_limit  = hot_sel ? HOT_HIGH_SEL_C : HOT_LOW_SEL_C;
  assign is_cool    = temp < $signed(COOL_C);
  assign is_warm    = temp > $signed(WARM_C);
  assign beyond_cool_warm = is_cool || is_warm;

  // The reserved junction code regulates at the highest documented set point.
  always_comb begin
    unique case (junc_set)
      2'h0:    junc_limit = JUNC_80_C;
      2'h1:    junc_limit = JUNC_95_C;
      default: junc_limit = JUNC_110_C;
    endcase
  end

  always_comb begin
    next_suspend    = 1'b0;
    next_cur_red    = 1'b0;
    next_volt_red   = 1'b0;
    next_foldback   = i_junction_temp_c > junc_limit;
    // Cool and warm events are raised in every mode, including mode 0.
    next_cool_event = is_cool && !was_cool;
    next_warm_event = is_warm && !was_warm;
    unique case (thm_mode)
      THM_OFF:  next_suspend = 1'b0;
      THM_STOP: next_suspend = (temp > hot_limit) || (temp < cold_limit);
      THM_CV_CC: begin
        next_cur_red  = beyond_cool_warm;
        next_volt_red = beyond_cool_warm;
      end
      THM_CC:   next_cur_red = beyond_cool_warm;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (core_rst) begin
      suspend    <= 1'b0;
      cur_red    <= 1'b0;
      volt_red   <= 1'b0;
      foldback   <= 1'b0;
      cool_event <= 1'b0;
      warm_event <= 1'b0;
      was_cool   <= 1'b0;
      was_warm   <= 1'b0;
    end else begin
      suspend    <= next_suspend;
      cur_red    <= next_cur_red;
      volt_red   <= next_volt_red;
      foldback   <= next_foldback;
      cool_event <= next_cool_event;
      warm_event <= next_warm_event;
      was_cool   <= is_cool;
      was_warm   <= is_warm;
    end
  end

  assign o_charge_suspend   = suspend;
  assign o_current_reduce   = cur_red;
  assign o_voltage_reduce   = volt_red;
  assign o_current_foldback = foldback;
  assign o_cool_event       = cool_event;
  assign o_warm_event       = warm_event;

  always_comb begin
    status                  = 8'h00;
    status[POS_ST_WD_EXP]   = wd_expired;
    status[POS_ST_SW_OPEN]  = switch_open;
    status[POS_ST_TREG]     = foldback;
    status[POS_ST_SUSPEND]  = suspend;
    status[POS_ST_CUR_RED]  = cur_red;
    status[POS_ST_VOLT_RED] = volt_red;
    status[POS_ST_OC_NOW]   = oc_cond;
  end

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (core_rst);

  a_wd_clear_restart: assert property (wd_restart |=> (wd_count == 17'h00000))
    else $error("Watchdog not restarted by clear code.");
  a_wd_no_clear: assert property ((wd_run && tick && wd_count < wd_limit)
    |=> (wd_count == $past(wd_count) + 17'h00001))
    else $error("Watchdog cleared without clear code.");
  a_wd_period_sel: assert property (wd_limit == (wd_short ? WD_SHORT_MS : WD_LONG_MS))
    else $error("Watchdog period wrong.");
  a_legacy_inert: assert property ((!oc_done && !wr_status) |=> !$rose(switch_open))
    else $error("Switch opened without qualified overcurrent.");
  a_oc_open: assert property ((oc_done && !keep_switch) |=> o_battery_system_switch_open)
    else $error("Switch not opened after overcurrent.");
  a_oc_keep_closed: assert property ((keep_switch && !switch_open) |=> !switch_open)
    else $error("Switch opened while keep bit set.");
  a_oc_thresh_off: assert property ((oc_thresh == 2'h0) |-> !oc_cond)
    else $error("Overcurrent seen while threshold disabled.");
  a_no_input_gate: assert property ((!i_input_present && !no_input_oc) |-> !oc_cond)
    else $error("Overcurrent checked without input supply.");
  a_mode_off: assert property (
    (thm_mode == THM_OFF) |=> (!suspend && !cur_red && !volt_red))
    else $error("Mode 0 altered charging.");
  a_mode_stop: assert property ((thm_mode == THM_STOP && temp > hot_limit) |=> suspend)
    else $error("Mode 1 did not stop charging when hot.");
  a_mode_cv_cc: assert property (
    (thm_mode == THM_CV_CC && beyond_cool_warm) |=> (cur_red && volt_red))
    else $error("Mode 2 did not reduce current and voltage.");
  a_mode_cc: assert property ((thm_mode == THM_CC) |=> !volt_red)
    else $error("Mode 3 changed the voltage.");
  a_junc_fold: assert property (
    (i_junction_temp_c > junc_limit) |=> (foldback && status[POS_ST_TREG]))
    else $error("Junction foldback missing.");
  a_cold_hot_sel: assert property (
    (cold_limit == (cold_sel ? COLD_HIGH_C : COLD_LOW_C))
      && (hot_limit == (hot_sel ? HOT_HIGH_SEL_C : HOT_LOW_SEL_C)))
    else $error("Temperature threshold select wrong.");
  a_reset_defaults: assert property (
    $past(core_rst) |-> (switch_cfg == RST_SWITCH_CFG && thermal_cfg == RST_THERMAL_CFG))
    else $error("Fields not at defaults after reset.");
  a_oc_restart: assert property (!oc_cond |=> (oc_count == 17'h00000))
    else $error("Overcurrent qualification not restarted.");
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
// Purpose: Self-checking bench for the charger protection and thermal registers.
// Assumes: The tick is shortened to two cycles, so one millisecond is two clock cycles.
// Notes:   The 80 s watchdog period would outrun the cycle budget, so only 32 s is timed.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import charger_cfg_pkg::*;
  localparam int TK    = 2;
  localparam int LIMIT = 95000;
  logic        clk, rst, crst_n, psel, penable, pwrite, pready, pslverr, wd_en, pres;
  logic        wd_exp, sw_open, sus, cur_red, volt_red, fold, cool, warm;
  logic [7:0]  paddr, btemp, jtemp;
  logic [31:0] pwdata, prdata, q;
  logic [3:0]  pstrb;
  logic [11:0] bcur;
  logic [2:0]  thm_out;
  int          bad_count, checked, cyc, nwarm, ncool, n0;
  int          ocfg[8] = '{8'hB0, 8'hB0, 8'h90, 8'hA0, 8'h80, 8'hB8, 8'h30, 8'hB0};
  int          opres[8] = '{1, 1, 1, 1, 1, 1, 0, 0};
  int          ocur[8] = '{3201, 3200, 2201, 2801, 4000, 3201, 3201, 3201};
  int          oexp[8] = '{1, 0, 1, 1, 0, 0, 0, 1};
  int          temps[5] = '{50, 65, -5, 57, 5};
  int          lims[3] = '{80, 95, 110};

  assign thm_out = {volt_red, cur_red, sus};

  charger_protect_thermal_cfg #(.TICK_CYCLES_P(TK)) dut (
    .i_ref_clk(clk), .i_sys_rst(rst), .i_core_digital_reset_n(crst_n),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_watchdog_enable(wd_en), .i_input_present(pres),
    .i_batt_current_ma(bcur), .i_batt_temp_c(btemp), .i_junction_temp_c(jtemp),
    .o_watchdog_expired(wd_exp), .o_battery_system_switch_open(sw_open),
    .o_charge_suspend(sus), .o_current_reduce(cur_red), .o_voltage_reduce(volt_red),
    .o_current_foldback(fold), .o_cool_event(cool), .o_warm_event(warm));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (warm === 1'b1) nwarm++;
    if (cool === 1'b1) ncool++;
    if (cyc == LIMIT) begin
      bad_count++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Starts on the edge after entry so a release from the last call never collides.
  task automatic apb(input logic dir, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rq, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= dir;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // The wait ends once pready is high; the bench timeout ends it if pready never rises.
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rq = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rq;
    logic        e;
    apb(1'b1, a, d, rq, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] rq);
    logic e;
    apb(1'b0, a, 32'h0, rq, e);
  endtask

  function automatic logic [2:0] thm_exp(input logic [7:0] c, input int t);
    int   hot;
    int   cold;
    logic x;
    hot = c[5] ? 55 : 60;
    cold = c[4] ? 10 : 0;
    x = (t > 45) || (t < 10);
    case (c[1:0])
      2'h1: thm_exp = {2'b00, (t > hot) || (t < cold)};
      2'h2: thm_exp = {x, x, 1'b0};
      2'h3: thm_exp = {1'b0, x, 1'b0};
      default: thm_exp = 3'h0;
    endcase
  endfunction

  initial begin
    logic e;
    {psel, penable, pwrite, wd_en, pres, crst_n, rst} = 7'h03;
    {paddr, pwdata, pstrb, bcur} = '0;
    pstrb = 4'hF;
    btemp = 8'h19;
    jtemp = 8'h19;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(8'h44, q); chk("switch cfg reset", 32'h30, q);
    rd(8'h48, q); chk("thermal cfg reset", 32'h05, q);
    apb(1'b0, 8'h50, 32'h0, q, e); chk("unmapped error", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
    chk("ready", 32'h1, {31'h0, pready});
    wr(8'h44, 32'h34); rd(8'h44, q); chk("legacy bit store", 32'h34, q);
    pstrb <= 4'h0;
    wr(8'h44, 32'hFF); rd(8'h44, q); chk("strobe off write", 32'h34, q);
    pstrb <= 4'hF;
    for (int i = 0; i < 8; i++) begin
      wr(8'h44, ocfg[i]);
      pres <= opres[i][0];
      bcur <= 12'(ocur[i]);
      cycles(26); chk("switch open early", 32'h0, sw_open);
      cycles(14); chk("switch open", oexp[i], sw_open);
      bcur <= 12'h0;
      wr(8'h4C, 32'h2);
      cycles(1); chk("switch open cleared", 32'h0, sw_open);
    end
    wr(8'h44, 32'hB0);
    bcur <= 12'hC81;
    cycles(20);
    bcur <= 12'h0;
    cycles(4);
    bcur <= 12'hC81;
    cycles(26); chk("qualify restart", 32'h0, sw_open);
    cycles(14); chk("qualify complete", 32'h1, sw_open);
    bcur <= 12'h0;
    wr(8'h4C, 32'h2);
    for (int m = 0; m < 4; m++) begin
      for (int s = 0; s < 4; s++) begin
        wr(8'h48, 32'(m | 4 | (s << 4))); rd(8'h48, q);
        chk("thermal cfg store", 32'(m | 4 | (s << 4)), q);
        for (int k = 0; k < 5; k++) begin
          btemp <= 8'(temps[k]);
          cycles(3);
          chk("thermal outputs", thm_exp(8'(q), temps[k]), thm_out);
        end
      end
    end
    wr(8'h48, 32'h04);
    btemp <= 8'h14;
    cycles(3);
    n0 = nwarm;
    btemp <= 8'h32;
    cycles(3); chk("warm event", 32'(n0 + 1), nwarm);
    n0 = ncool;
    btemp <= 8'h05;
    cycles(3); chk("cool event", 32'(n0 + 1), ncool);
    btemp <= 8'h19;
    for (int c = 0; c < 3; c++) begin
      wr(8'h48, 32'((c << 2) | 1));
      jtemp <= 8'(lims[c]);
      cycles(3); chk("foldback at set point", 32'h0, fold);
      jtemp <= 8'(lims[c] + 1);
      cycles(3); chk("foldback above", 32'h1, fold);
      rd(8'h4C, q); chk("regulation flag", 32'h1, {31'h0, q[POS_ST_TREG]});
      jtemp <= 8'h19;
    end
    wr(8'h44, 32'hC7);
    crst_n <= 1'b0;
    cycles(2);
    crst_n <= 1'b1;
    rd(8'h44, q); chk("switch cfg core reset", 32'h30, q);
    rd(8'h48, q); chk("thermal cfg core reset", 32'h05, q);
    // Restart at 8 s, then the three non-clearing codes at 20 s; expiry due near 40 s.
    wr(8'h44, 32'h40);
    wd_en <= 1'b1;
    cycles(8000 * TK);
    wr(8'h44, 32'h41);
    cycles(12000 * TK);
    wr(8'h44, 32'h42);
    wr(8'h44, 32'h43);
    wr(8'h44, 32'h40);
    cycles(19000 * TK); chk("watchdog restarted", 32'h0, wd_exp);
    cycles(2000 * TK); chk("watchdog expired", 32'h1, wd_exp);
    wd_en <= 1'b0;
    wr(8'h4C, 32'h1); cycles(1); chk("watchdog flag cleared", 32'h0, wd_exp);
    final_report();
  end
endmodule
`default_nettype wire
